// >>> common/tpm_regs.vh
// Purpose: Register map, fields and constants of the PWM timer block
// Assumes: APB byte addressing, 32-bit data
// Notes: Included by hw/tpm_top.v
`ifndef TPM_REGS_VH
`define TPM_REGS_VH
// Byte offsets
`define TPM_OFS_CTRL 8'h00
`define TPM_OFS_CMPA 8'h04
`define TPM_OFS_CMPB 8'h08
`define TPM_OFS_CNT 8'h0C
`define TPM_OFS_STAT 8'h10
// Control field positions
`define TPM_WAVE_LSB 0
`define TPM_WAVE_MSB 2
`define TPM_COMA_LSB 4
`define TPM_COMA_MSB 5
`define TPM_COMB_LSB 6
`define TPM_COMB_MSB 7
`define TPM_DIRA_BIT 8
`define TPM_DIRB_BIT 9
`define TPM_PSC_LSB 12
`define TPM_PSC_MSB 14
`define TPM_ASYNC_BIT 16
// Status bits
`define TPM_ST_OVF 0
`define TPM_ST_MATCHA 1
`define TPM_ST_MATCHB 2
// Reset values
`define TPM_CTRL_RST 17'h00000
`define TPM_CMP_RST 8'h00
`define TPM_CNT_RST 8'h00
// Waveform modes
`define TPM_MODE_PC_FF 3'h1
`define TPM_MODE_FAST_FF 3'h3
`define TPM_MODE_PC_A 3'h5
`define TPM_MODE_FAST_A 3'h7
// Counter limits
`define TPM_BOTTOM 8'h00
`define TPM_MAX 8'hFF
// Compare output modes
`define TPM_COM_OFF 2'h0
`define TPM_COM_TOGGLE 2'h1
// Prescaler width covers division by 1024
`define TPM_PSC_W 10
`endif

// >>> hw/tpm_top.v
// Purpose: Fast and phase correct PWM timer with two compare channels
// Assumes: APB slave on pclk, one wait state per access
// Notes: Normal and CTC modes only hold the counter
// Operation
// - Modes 3 and 7 count single-slope
// - Fast TOP is 0xFF or compare A
// - Fast output clears on match, sets BOTTOM
// - At TOP counter clears next tick
// - Fast mode flags overflow at TOP
// - Mode two non-inverted, three inverted
// - Pin driven only when direction is output
// - Fast extremes: spike or constant level
// - Toggle mode gives half-rate square wave
// - Fast compare values are double buffered
// - Modes 1 and 5 count dual-slope
// - Phase correct holds TOP one tick
// - Up match clears, down match sets
// - Phase correct flags overflow at BOTTOM
// - Phase correct extremes give constant levels
// - Leaving MAX keeps symmetry at BOTTOM
// - Missed up match still transitions
// - Counter advances only on timer tick
// - Prescale factors 1 to 1024
// - Channel A toggle needs top mode bit
// - Compare equal TOP acts at TOP
`timescale 1ns/10ps
`include "tpm_regs.vh"
`default_nettype none

module tpm_top #(
   parameter ADDR_W = 8
) (
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire async_tick_pin,
   output reg compare_output_a,
   output reg compare_output_a_oe,
   output reg compare_output_b,
   output reg compare_output_b_oe
);

   // Prescaler mask for select code, all ones means divide by 1024
   function [`TPM_PSC_W-1:0] tpm_psc_mask;
      input [2:0] sel;
      begin
         case (sel)
            3'h1: tpm_psc_mask = 10'h000;
            3'h2: tpm_psc_mask = 10'h007;
            3'h3: tpm_psc_mask = 10'h01F;
            3'h4: tpm_psc_mask = 10'h03F;
            3'h5: tpm_psc_mask = 10'h07F;
            3'h6: tpm_psc_mask = 10'h0FF;
            3'h7: tpm_psc_mask = 10'h3FF;
            default: tpm_psc_mask = 10'h000;
         endcase
      end
   endfunction

   // Next compare output state for one channel on a timer tick
   function tpm_next_oc;
      input oc;
      input [1:0] com;
      input fast;
      input up;
      input wrap;
      input top_turn;
      input bot_turn;
      input match;
      input ocr_top;
      input ocr_zero;
      input tog_ok;
      begin
         tpm_next_oc = oc;
         if (com == `TPM_COM_TOGGLE) begin
            if (tog_ok && match) begin
               tpm_next_oc = ~oc;
            end
         end else if (com[1]) begin
            // com[0] is the polarity
            if (fast) begin
               if (wrap) begin
                  tpm_next_oc = ~com[0];
               end else if (match) begin
                  tpm_next_oc = com[0];
               end
            end else begin
               if (top_turn) begin
                  // Missed up match is made good here
                  tpm_next_oc = ocr_top ? ~com[0] : com[0];
               end else if (bot_turn) begin
                  // Symmetry transition without a match
                  tpm_next_oc = ocr_zero ? com[0] : ~com[0];
               end else if (match) begin
                  tpm_next_oc = up ? com[0] : ~com[0];
               end
            end
         end
      end
   endfunction

   // Output enable: pin driven only with direction set and compare mode active
   function tpm_pin_oe;
      input dir;
      input [1:0] com;
      input tog_ok;
      begin
         tpm_pin_oe = dir && (com[1] || (com == `TPM_COM_TOGGLE && tog_ok));
      end
   endfunction

   reg [16:0] ctrl;
   reg [7:0] buf_a;
   reg [7:0] buf_b;
   reg [7:0] ocr_a;
   reg [7:0] ocr_b;
   reg [7:0] counter_value;
   reg count_up;
   reg overflow_flag;
   reg channel_a_match_flag;
   reg channel_b_match_flag;
   reg oc_a;
   reg oc_b;
   reg [`TPM_PSC_W-1:0] psc_count;
   reg sync1;
   reg sync2;
   reg sync3;

   wire [2:0] waveform_mode_field = ctrl[`TPM_WAVE_MSB:`TPM_WAVE_LSB];
   wire waveform_mode_top_bit = waveform_mode_field[2];
   wire [1:0] com_a = ctrl[`TPM_COMA_MSB:`TPM_COMA_LSB];
   wire [1:0] com_b = ctrl[`TPM_COMB_MSB:`TPM_COMB_LSB];
   wire [2:0] psc_sel = ctrl[`TPM_PSC_MSB:`TPM_PSC_LSB];
   wire async_mode = ctrl[`TPM_ASYNC_BIT];

   // Mode decode
   wire mode_fast = (waveform_mode_field == `TPM_MODE_FAST_FF) ||
                    (waveform_mode_field == `TPM_MODE_FAST_A);
   wire mode_pc = (waveform_mode_field == `TPM_MODE_PC_FF) ||
                  (waveform_mode_field == `TPM_MODE_PC_A);

   // TOP is 0xFF or channel A compare
   wire [7:0] top_value = waveform_mode_top_bit ? ocr_a : `TPM_MAX;

   // Source pulse: pclk in sync mode, synchronised pin edge in async mode
   wire async_pulse = sync2 & ~sync3;
   wire src_pulse = async_mode ? async_pulse : 1'b1;
   wire [`TPM_PSC_W-1:0] psc_mask = tpm_psc_mask(psc_sel);
   // Timer clock enable, code 0 stops the timer
   wire timer_clock_enable = src_pulse && (psc_sel != 3'h0) &&
                             ((psc_count & psc_mask) == psc_mask);

   // Counter events on this tick
   wire fast_wrap = mode_fast && (counter_value == top_value);
   wire pc_top = mode_pc && count_up && (counter_value >= top_value);
   wire pc_bot = mode_pc && !count_up && (counter_value == `TPM_BOTTOM);
   wire match_a = (counter_value == ocr_a);
   wire match_b = (counter_value == ocr_b);
   wire pwm_on = mode_fast || mode_pc;

   // APB decode
   wire apb_setup = psel && penable && !pready;
   wire apb_access = psel && penable && pready;
   wire apb_wr = apb_access && pwrite;
   wire [7:0] apb_ofs = paddr[7:0];
   wire wr_ctrl = apb_wr && (apb_ofs == `TPM_OFS_CTRL);
   wire wr_cmpa = apb_wr && (apb_ofs == `TPM_OFS_CMPA);
   wire wr_cmpb = apb_wr && (apb_ofs == `TPM_OFS_CMPB);
   wire wr_cnt = apb_wr && (apb_ofs == `TPM_OFS_CNT);
   wire wr_stat = apb_wr && (apb_ofs == `TPM_OFS_STAT);

   reg [31:0] next_prdata;
   reg next_pslverr;

   // Read mux and unmapped-address error
   always @* begin
      next_prdata = 32'h00000000;
      next_pslverr = 1'b0;
      case (apb_ofs)
         `TPM_OFS_CTRL: next_prdata = {15'h0000, ctrl};
         `TPM_OFS_CMPA: next_prdata = {24'h000000, buf_a};
         `TPM_OFS_CMPB: next_prdata = {24'h000000, buf_b};
         `TPM_OFS_CNT: next_prdata = {24'h000000, counter_value};
         `TPM_OFS_STAT: next_prdata = {29'h00000000, channel_b_match_flag,
                                        channel_a_match_flag, overflow_flag};
         default: next_pslverr = 1'b1;
      endcase
   end

   // APB handshake, one wait state so the answer comes from flops
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (ce) begin
         pready <= apb_setup;
         pslverr <= apb_setup && next_pslverr;
         if (apb_setup && !pwrite) begin
            prdata <= next_prdata;
         end
      end
   end

   // Pin synchroniser and prescaler
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
         psc_count <= {`TPM_PSC_W{1'b0}};
      end else if (ce) begin
         sync1 <= async_tick_pin;
         sync2 <= sync1;
         sync3 <= sync2;
         if (psc_sel == 3'h0) begin
            psc_count <= {`TPM_PSC_W{1'b0}};
         end else if (src_pulse) begin
            psc_count <= psc_count + 10'h001;
         end
      end
   end

   // Configuration and compare buffers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `TPM_CTRL_RST;
         buf_a <= `TPM_CMP_RST;
         buf_b <= `TPM_CMP_RST;
      end else if (ce) begin
         if (wr_ctrl) begin
            ctrl <= pwdata[16:0];
         end
         if (wr_cmpa) begin
            buf_a <= pwdata[7:0];
         end
         if (wr_cmpb) begin
            buf_b <= pwdata[7:0];
         end
      end
   end

   // Counter sequencing and buffer transfer
   // Only moves on a timer tick, so prescaled modes see each step once
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_value <= `TPM_CNT_RST;
         count_up <= 1'b1;
         ocr_a <= `TPM_CMP_RST;
         ocr_b <= `TPM_CMP_RST;
      end else if (ce) begin
         if (!pwm_on) begin
            // Without double buffering the buffer acts directly
            ocr_a <= buf_a;
            ocr_b <= buf_b;
            count_up <= 1'b1;
         end
         if (wr_cnt) begin
            counter_value <= pwdata[7:0];
         end else if (timer_clock_enable && mode_fast) begin
            if (fast_wrap) begin
               counter_value <= `TPM_BOTTOM;
               ocr_a <= buf_a;
               ocr_b <= buf_b;
            end else begin
               counter_value <= counter_value + 8'h01;
            end
         end else if (timer_clock_enable && mode_pc) begin
            if (pc_top) begin
               // TOP was shown for this whole tick
               counter_value <= (counter_value == `TPM_BOTTOM) ?
                                `TPM_BOTTOM : counter_value - 8'h01;
               count_up <= 1'b0;
               ocr_a <= buf_a;
               ocr_b <= buf_b;
            end else if (pc_bot) begin
               counter_value <= (top_value == `TPM_BOTTOM) ?
                                `TPM_BOTTOM : 8'h01;
               count_up <= 1'b1;
            end else if (count_up) begin
               counter_value <= counter_value + 8'h01;
            end else begin
               counter_value <= counter_value - 8'h01;
            end
         end
      end
   end

   // Status flags, write one to clear, a set in the same cycle wins
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_flag <= 1'b0;
         channel_a_match_flag <= 1'b0;
         channel_b_match_flag <= 1'b0;
      end else if (ce) begin
         overflow_flag <= (overflow_flag & ~(wr_stat & pwdata[`TPM_ST_OVF])) |
                          (timer_clock_enable & !wr_cnt &
                           (fast_wrap | pc_bot));
         channel_a_match_flag <= (channel_a_match_flag &
                                  ~(wr_stat & pwdata[`TPM_ST_MATCHA])) |
                                 (timer_clock_enable & !wr_cnt & pwm_on & match_a);
         channel_b_match_flag <= (channel_b_match_flag &
                                  ~(wr_stat & pwdata[`TPM_ST_MATCHB])) |
                                 (timer_clock_enable & !wr_cnt & pwm_on & match_b);
      end
   end

   // Internal compare output states, kept even while the pin is released
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oc_a <= 1'b0;
         oc_b <= 1'b0;
      end else if (ce) begin
         if (timer_clock_enable && pwm_on && !wr_cnt) begin
            oc_a <= tpm_next_oc(oc_a, com_a, mode_fast, count_up, fast_wrap,
                                pc_top, pc_bot, match_a, ocr_a == top_value,
                                ocr_a == `TPM_BOTTOM, waveform_mode_top_bit);
            // Channel B toggle is reserved, so it never toggles
            oc_b <= tpm_next_oc(oc_b, com_b, mode_fast, count_up, fast_wrap,
                                pc_top, pc_bot, match_b, ocr_b == top_value,
                                ocr_b == `TPM_BOTTOM, 1'b0);
         end
      end
   end

   // Pin stage, one pclk behind the internal state
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_output_a <= 1'b0;
         compare_output_a_oe <= 1'b0;
         compare_output_b <= 1'b0;
         compare_output_b_oe <= 1'b0;
      end else if (ce) begin
         compare_output_a <= oc_a;
         compare_output_b <= oc_b;
         compare_output_a_oe <= tpm_pin_oe(ctrl[`TPM_DIRA_BIT], com_a,
                                           waveform_mode_top_bit);
         compare_output_b_oe <= tpm_pin_oe(ctrl[`TPM_DIRB_BIT], com_b,
                                           1'b0);
      end
   end

endmodule

`default_nettype wire

// >>> testbench/tpm_load.sv
// Purpose: Load on one PWM pin that counts the cycles it sees high
// Assumes: A pull-down holds the pin low whenever it is released
// Notes: Counting over whole periods makes the start phase irrelevant
`timescale 1ns/10ps
`default_nettype none
module tpm_load (
   input wire logic pclk,
   input wire logic pin,
   input wire logic pin_oe,
   input wire logic clr,
   output logic [15:0] high_cnt
);
   // A released pin reads the pull-down level, never the last driven value
   wire level = pin_oe ? pin : 1'b0;
   // High-time counter, restarted by the bench
   always @(posedge pclk) begin
      if (clr)
         high_cnt <= 16'h0000;
      else if (level === 1'b1)
         high_cnt <= high_cnt + 16'h0001;
   end
endmodule
`default_nettype wire

// >>> testbench/tpm_top_asserts.sv
// Purpose: Port-level checks of the PWM timer
// Assumes: Control and compare A shadows follow completed APB writes
// Notes: A long write-free window stands in for the hidden counter state
`timescale 1ns/10ps
`default_nettype none
module tpm_top_asserts #(
   parameter ADDR_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic compare_output_a,
   input wire logic compare_output_a_oe,
   input wire logic compare_output_b,
   input wire logic compare_output_b_oe
);
   logic [16:0] ctrl;
   logic [7:0] cmpa;
   logic [11:0] calm;
   wire wr_done = psel && penable && pready && pwrite && !pslverr;
   // Shadows; calm counts cycles since the last write so outputs may settle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= 17'h00000;
         cmpa <= 8'h00;
         calm <= 12'h000;
      end else if (wr_done) begin
         calm <= 12'h000;
         if (paddr[7:0] == 8'h00)
            ctrl <= pwdata[16:0];
         if (paddr[7:0] == 8'h04)
            cmpa <= pwdata[7:0];
      end else if (calm != 12'hFFF) begin
         calm <= calm + 12'h001;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_wait;
      psel && penable && !pready && ce;
   endsequence
   sequence s_idle;
      !psel || !penable;
   endsequence
   wire run1 = ctrl[14:12] == 3'h1 && !ctrl[16];
   a_ready_one_wait: assert property (s_wait |=> pready) else $error("pready late");
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready stuck");
   a_ready_idle: assert property (s_idle |=> !pready) else $error("pready unasked");
   a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
   a_oe_a_drive: assert property (calm > 3 |-> compare_output_a_oe ==
      (ctrl[8] && (ctrl[5] || (ctrl[5:4] == 2'h1 && ctrl[2])))) else $error("oe a wrong");
   a_oe_b_drive: assert property (calm > 3 |-> compare_output_b_oe == (ctrl[9] && ctrl[7]))
      else $error("oe b wrong");
   a_fast_max_level: assert property (calm > 600 && run1 && ctrl[2:0] == 3'h3 && ctrl[5]
      && cmpa == 8'hFF |-> compare_output_a == !ctrl[4]) else $error("fast max not constant");
   a_pc_end_level: assert property (calm > 1050 && run1 && ctrl[2:0] == 3'h1 && ctrl[5]
      && (cmpa == 8'h00 || cmpa == 8'hFF) |-> compare_output_a == ((cmpa == 8'hFF) ^ ctrl[4]))
      else $error("pc extreme not constant");
   a_freeze_no_ce: assert property (!ce |=> $stable(compare_output_a) && $stable(compare_output_b))
      else $error("output moved without enable");
endmodule
bind tpm_top tpm_top_asserts #(.ADDR_W(ADDR_W)) u_tpm_top_asserts (.pclk(pclk), .presetn(presetn),
   .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .pslverr(pslverr), .compare_output_a(compare_output_a),
   .compare_output_a_oe(compare_output_a_oe), .compare_output_b(compare_output_b),
   .compare_output_b_oe(compare_output_b_oe));
`default_nettype wire

// >>> testbench/tb_tpm_top.sv
// Purpose: Self-checking bench of the PWM timer
// Assumes: Prescale code 1 gives one timer tick per pclk
// Notes: Duty is counted by the loads over whole periods
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
   $display("[ERR] %s exp %0h got %0h", nm, exp, got); end end
module tb_tpm_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic tick_pin = 1'b0;
   logic clr = 1'b0;
   logic [31:0] rd;
   logic er;
   wire [31:0] prdata;
   wire pready, pslverr, oa, oa_oe, ob, ob_oe;
   wire [15:0] cnt_a, cnt_b;
   int num_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   tpm_top #(.ADDR_W(8)) u_tpm_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .async_tick_pin(tick_pin), .compare_output_a(oa),
      .compare_output_a_oe(oa_oe), .compare_output_b(ob), .compare_output_b_oe(ob_oe));
   tpm_load u_tpm_load_a (.pclk(pclk), .pin(oa), .pin_oe(oa_oe), .clr(clr), .high_cnt(cnt_a));
   tpm_load u_tpm_load_b (.pclk(pclk), .pin(ob), .pin_oe(ob_oe), .clr(clr), .high_cnt(cnt_b));
   // 125 MHz clock
   initial begin
      forever #4 pclk = ~pclk;
   end
   // Watchdog on the whole run
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         num_errors++;
         $display("[ERR] run time exp %0d got %0d", 40000, cyc);
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // One APB transfer; request held until pready is sampled high
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         num_errors++;
         $display("[ERR] pready exp 1 got %0h", pready);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Configure both channels, let them settle, count high cycles over win
   task automatic duty(input logic [2:0] m, input logic [1:0] ca, input logic [1:0] cb,
      input logic [7:0] va, input logic [7:0] vb, input logic [1:0] dir, input int win,
      input logic [15:0] ea, input logic [15:0] eb);
      xfer(8'h04, 1'b1, {24'h000000, va});
      xfer(8'h08, 1'b1, {24'h000000, vb});
      xfer(8'h00, 1'b1, {15'h0000, 2'h0, 3'h1, 2'h0, dir, cb, ca, 1'b0, m});
      repeat (1100) @(posedge pclk);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      repeat (win) @(posedge pclk);
      #1;
      `CHK("duty a", ea, cnt_a)
      `CHK("duty b", eb, cnt_b)
   endtask
   // Main sequence
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         xfer(8'(i * 4), 1'b0, 32'h00000000);
         `CHK("reset value", 32'h00000000, rd)
      end
      xfer(8'h14, 1'b0, 32'h00000000);
      `CHK("unmapped err", 1'b1, er)
      duty(3'h3, 2'h2, 2'h3, 8'h3F, 8'h3F, 2'h3, 256, 16'h0040, 16'h00C0);
      duty(3'h3, 2'h2, 2'h2, 8'h00, 8'hFF, 2'h3, 256, 16'h0001, 16'h0100);
      duty(3'h3, 2'h3, 2'h2, 8'hFF, 8'h00, 2'h3, 256, 16'h0000, 16'h0001);
      duty(3'h7, 2'h1, 2'h2, 8'h63, 8'h31, 2'h3, 200, 16'h0064, 16'h0064);
      duty(3'h1, 2'h2, 2'h3, 8'h40, 8'h40, 2'h3, 510, 16'h0080, 16'h017E);
      duty(3'h1, 2'h2, 2'h2, 8'h00, 8'hFF, 2'h3, 510, 16'h0000, 16'h01FE);
      duty(3'h1, 2'h3, 2'h3, 8'hFF, 8'h00, 2'h3, 510, 16'h0000, 16'h01FE);
      duty(3'h5, 2'h0, 2'h2, 8'h63, 8'h31, 2'h3, 198, 16'h0000, 16'h0062);
      duty(3'h3, 2'h1, 2'h2, 8'h10, 8'h10, 2'h1, 256, 16'h0000, 16'h0000);
      xfer(8'h04, 1'b0, 32'h00000000);
      `CHK("compare buffer", 32'h00000010, rd)
      ce <= 1'b0;
      repeat (50) @(posedge pclk);
      ce <= 1'b1;
      xfer(8'h00, 1'b1, 32'h00000003);
      xfer(8'h0C, 1'b1, 32'h000000FE);
      xfer(8'h10, 1'b1, 32'h00000007);
      xfer(8'h10, 1'b0, 32'h00000000);
      `CHK("flag cleared", 1'b0, rd[0])
      xfer(8'h00, 1'b1, 32'h00001003);
      repeat (10) @(posedge pclk);
      xfer(8'h10, 1'b0, 32'h00000000);
      `CHK("fast overflow", 1'b1, rd[0])
      xfer(8'h00, 1'b1, 32'h00001001);
      xfer(8'h10, 1'b1, 32'h00000007);
      repeat (600) @(posedge pclk);
      xfer(8'h10, 1'b0, 32'h00000000);
      `CHK("pc overflow", 1'b1, rd[0])
      xfer(8'h00, 1'b1, 32'h00000000);
      xfer(8'h0C, 1'b1, 32'h00000010);
      xfer(8'h00, 1'b1, 32'h00011003);
      repeat (20) @(posedge pclk);
      xfer(8'h0C, 1'b0, 32'h00000000);
      `CHK("async idle", 32'h00000010, rd)
      repeat (5) begin
         tick_pin <= 1'b1;
         repeat (4) @(posedge pclk);
         tick_pin <= 1'b0;
         repeat (4) @(posedge pclk);
      end
      xfer(8'h0C, 1'b0, 32'h00000000);
      `CHK("async count", 32'h00000015, rd)
      print_verdict();
   end
endmodule
`undef CHK
`default_nettype wire
